/* File: verilog/ucf_pkg.sv */
package ucf_pkg;

   // configuration bank: patterns for header bytes 1..4, then masks for bytes 1..4
   localparam logic [7:0] UCF_PAT1_ADDR = 8'h58;
   localparam logic [7:0] UCF_PAT2_ADDR = 8'h59;
   localparam logic [7:0] UCF_PAT3_ADDR = 8'h5a;
   localparam logic [7:0] UCF_PAT4_ADDR = 8'h5b;
   localparam logic [7:0] UCF_MSK1_ADDR = 8'h5c;
   localparam logic [7:0] UCF_MSK2_ADDR = 8'h5d;
   localparam logic [7:0] UCF_MSK3_ADDR = 8'h5e;
   localparam logic [7:0] UCF_MSK4_ADDR = 8'h5f;
   localparam logic [7:0] UCF_CTRL_ADDR = 8'h40;
   localparam logic [7:0] UCF_STAT_ADDR = 8'h41;

   localparam int UCF_NUM_BYTES = 4;
   localparam int UCF_NUM_CFG = 8;

   localparam logic [7:0] UCF_PAT_RST = 8'h00;
   localparam logic [7:0] UCF_MSK_RST = 8'hff;
   localparam logic [7:0] UCF_CTRL_RST = 8'h01;
   localparam logic [7:0] UCF_STAT_RST = 8'h00;
   localparam logic [7:0] UCF_RD_IDLE = 8'h00;

   localparam int UCF_CTRL_UNI_BIT = 0;
   localparam int UCF_STAT_MATCH_BIT = 0;
   localparam int UCF_STAT_SEEN_BIT = 1;

   // header bytes 1..4 in arrival order, byte 1 in the top bits
   typedef struct packed {
      logic [7:0] b1;
      logic [7:0] b2;
      logic [7:0] b3;
      logic [7:0] b4;
   } ucf_hdr_t;

endpackage

/* File: verilog/ucf_cfg_reg.sv */
`timescale 1ns/1ps
module ucf_cfg_reg #(
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic wr_en,
   input wire logic [7:0] wdata,
   output logic [7:0] value_q
);

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         value_q <= RST_VAL;
      end else if (wr_en) begin
         value_q <= wdata;
      end
   end

endmodule // ucf_cfg_reg

/* File: verilog/ucf_byte_cmp.sv */
`timescale 1ns/1ps
module ucf_byte_cmp (
   input wire logic [7:0] hdr_byte,
   input wire logic [7:0] pattern,
   input wire logic [7:0] mask,
   output logic equal
);

   // a cleared mask bit drops out of the xor, so it can never cause a miss
   assign equal = ((hdr_byte ^ pattern) & mask) == 8'h00;

endmodule // ucf_byte_cmp

/* File: verilog/ucf_filter.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module ucf_filter (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic hdr_valid,
   input wire ucf_pkg::ucf_hdr_t hdr,
   output logic match_valid,
   output logic user_match
);

   logic [ucf_pkg::UCF_NUM_CFG-1:0][7:0] cfg_q;
   logic [ucf_pkg::UCF_NUM_CFG-1:0] cfg_wr;
   logic [ucf_pkg::UCF_NUM_BYTES-1:0][7:0] hdr_bytes;
   logic [ucf_pkg::UCF_NUM_BYTES-1:0] byte_eq;
   logic [31:0] pat_all;
   logic [31:0] msk_all;
   logic [7:0] ctrl_q;
   logic [7:0] stat_q;
   logic uni_mode;
   logic match_valid_q;
   logic user_match_q;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic first_q;
   logic [7:0] user_filter_pattern_byte1;
   logic [7:0] user_filter_pattern_byte2;
   logic [7:0] user_filter_pattern_byte3;
   logic [7:0] user_filter_pattern_byte4;
   logic [7:0] user_filter_mask_byte1;
   logic [7:0] user_filter_mask_byte2;
   logic [7:0] user_filter_mask_byte3;
   logic [7:0] user_filter_mask_byte4;

   assign hdr_bytes = hdr;
   assign uni_mode = ctrl_q[ucf_pkg::UCF_CTRL_UNI_BIT];
   assign pat_all = {user_filter_pattern_byte1, user_filter_pattern_byte2, user_filter_pattern_byte3,
      user_filter_pattern_byte4};
   assign msk_all = {user_filter_mask_byte1, user_filter_mask_byte2, user_filter_mask_byte3, user_filter_mask_byte4};

   // one name per register, so checks speak of the register and not of its slot in the bank
   assign user_filter_pattern_byte1 = cfg_q[0];
   assign user_filter_pattern_byte2 = cfg_q[1];
   assign user_filter_pattern_byte3 = cfg_q[2];
   assign user_filter_pattern_byte4 = cfg_q[3];
   assign user_filter_mask_byte1 = cfg_q[4];
   assign user_filter_mask_byte2 = cfg_q[5];
   assign user_filter_mask_byte3 = cfg_q[6];
   assign user_filter_mask_byte4 = cfg_q[7];

   // pattern and mask bank, contiguous from the byte-1 pattern
   genvar gi;
   generate
      for (gi = 0; gi < ucf_pkg::UCF_NUM_CFG; gi++) begin : g_cfg
         assign cfg_wr[gi] = reg_wr && (reg_addr == ucf_pkg::UCF_PAT1_ADDR + 8'(gi));
         ucf_cfg_reg #(
            .RST_VAL(gi < ucf_pkg::UCF_NUM_BYTES ? ucf_pkg::UCF_PAT_RST : ucf_pkg::UCF_MSK_RST)
         ) u_cfg (
            .sys_clk(sys_clk),
            .rstn(rstn),
            .wr_en(cfg_wr[gi]),
            .wdata(reg_wdata),
            .value_q(cfg_q[gi])
         );
      end
      // byte k+1 sits at hdr_bytes[3-k]; its pattern is cfg_q[k], its mask cfg_q[k+4]
      for (gi = 0; gi < ucf_pkg::UCF_NUM_BYTES; gi++) begin : g_cmp
         ucf_byte_cmp u_cmp (
            .hdr_byte(hdr_bytes[ucf_pkg::UCF_NUM_BYTES-1-gi]),
            .pattern(cfg_q[gi]),
            .mask(cfg_q[gi+ucf_pkg::UCF_NUM_BYTES]),
            .equal(byte_eq[gi])
         );
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_q <= ucf_pkg::UCF_CTRL_RST;
      end else if (reg_wr && reg_addr == ucf_pkg::UCF_CTRL_ADDR) begin
         ctrl_q <= reg_wdata;
      end
   end

   // result pulses only in uni mode so clear-channel traffic never sees the filter
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         match_valid_q <= 1'b0;
         user_match_q <= 1'b0;
      end else begin
         match_valid_q <= hdr_valid && uni_mode;
         user_match_q <= hdr_valid && uni_mode && (&byte_eq);
      end
   end

   // status: last verdict and a sticky seen-a-match bit; a read clears the sticky
   // bit, but a match in the same cycle wins
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         stat_q <= ucf_pkg::UCF_STAT_RST;
      end else begin
         if (match_valid_q) begin
            stat_q[ucf_pkg::UCF_STAT_MATCH_BIT] <= user_match_q;
         end
         if (user_match_q) begin
            stat_q[ucf_pkg::UCF_STAT_SEEN_BIT] <= 1'b1;
         end else if (reg_rd && reg_addr == ucf_pkg::UCF_STAT_ADDR) begin
            stat_q[ucf_pkg::UCF_STAT_SEEN_BIT] <= 1'b0;
         end
      end
   end

   always_comb begin
      rdata_d = ucf_pkg::UCF_RD_IDLE;
      if (reg_rd) begin
         if (reg_addr >= ucf_pkg::UCF_PAT1_ADDR && reg_addr <= ucf_pkg::UCF_MSK4_ADDR) begin
            rdata_d = cfg_q[3'(reg_addr - ucf_pkg::UCF_PAT1_ADDR)];
         end else if (reg_addr == ucf_pkg::UCF_CTRL_ADDR) begin
            rdata_d = ctrl_q;
         end else if (reg_addr == ucf_pkg::UCF_STAT_ADDR) begin
            rdata_d = stat_q;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= ucf_pkg::UCF_RD_IDLE;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         first_q <= 1'b0;
      end else begin
         first_q <= 1'b1;
      end
   end

   assign reg_rdata = rdata_q;
   assign match_valid = match_valid_q;
   assign user_match = user_match_q;

   a_masked_all_equal: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && uni_mode && (((hdr ^ pat_all) & msk_all) == 32'h0) |=> user_match && match_valid)
      else $error("masked header equal to pattern but no match");

   a_masked_miss_rejects: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && (((hdr ^ pat_all) & msk_all) != 32'h0) |=> !user_match)
      else $error("compared bit differs yet match reported");

   a_dont_care_bits: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && uni_mode && (((hdr ^ pat_all) & ~msk_all) != 32'h0)
      && (((hdr ^ pat_all) & msk_all) == 32'h0) |=> user_match)
      else $error("unmasked bit difference blocked a match");

   a_clear_channel_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !uni_mode |=> !match_valid && !user_match)
      else $error("filter acted outside uni mode");

   a_reset_defaults: assert property (@(posedge sys_clk) disable iff (!rstn)
      !first_q |-> pat_all == 32'h0 && msk_all == 32'hffffffff)
      else $error("pattern or mask not at reset value");

   a_mask_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && reg_addr == ucf_pkg::UCF_MSK3_ADDR ##1 reg_rd && reg_addr == ucf_pkg::UCF_MSK3_ADDR
      |=> reg_rdata == $past(reg_wdata, 2))
      else $error("mask register did not read back its write");

   a_pattern_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && reg_addr == ucf_pkg::UCF_PAT2_ADDR ##1 !reg_wr ##1 reg_rd && reg_addr == ucf_pkg::UCF_PAT2_ADDR
      |=> reg_rdata == $past(reg_wdata, 3))
      else $error("pattern register did not read back its write");

   a_byte2_pairing: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && (((hdr.b2 ^ cfg_q[1]) & cfg_q[5]) != 8'h00) |=> !user_match)
      else $error("byte 2 mismatch under its own mask ignored");

   a_header_gets_verdict: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && uni_mode
      |=> match_valid)
      else $error("header in uni mode got no verdict");

   a_idle_no_verdict: assert property (@(posedge sys_clk) disable iff (!rstn)
      !hdr_valid
      |=> !match_valid && !user_match)
      else $error("verdict without a header");

   a_match_implies_valid: assert property (@(posedge sys_clk) disable iff (!rstn)
      user_match
      |-> match_valid)
      else $error("match flagged without verdict strobe");

   a_full_mask_exact: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && uni_mode && msk_all == 32'hffffffff && hdr == pat_all
      |=> user_match)
      else $error("exact header under full mask not matched");

   a_full_mask_differs: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && msk_all == 32'hffffffff && hdr != pat_all
      |=> !user_match)
      else $error("differing header under full mask matched");

   a_byte1_pairing: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && (((hdr.b1 ^ user_filter_pattern_byte1) & user_filter_mask_byte1) != 8'h00)
      |=> !user_match)
      else $error("byte 1 mismatch under its own mask ignored");

   a_byte3_pairing: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && (((hdr.b3 ^ user_filter_pattern_byte3) & user_filter_mask_byte3) != 8'h00)
      |=> !user_match)
      else $error("byte 3 mismatch under its own mask ignored");

   a_byte4_pairing: assert property (@(posedge sys_clk) disable iff (!rstn)
      hdr_valid && (((hdr.b4 ^ user_filter_pattern_byte4) & user_filter_mask_byte4) != 8'h00)
      |=> !user_match)
      else $error("byte 4 mismatch under its own mask ignored");

   a_rdata_idle: assert property (@(posedge sys_clk) disable iff (!rstn)
      !reg_rd
      |=> reg_rdata == ucf_pkg::UCF_RD_IDLE)
      else $error("read data not idle without a read");

   a_unmapped_read: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && (reg_addr < ucf_pkg::UCF_PAT1_ADDR || reg_addr > ucf_pkg::UCF_MSK4_ADDR)
      && reg_addr != ucf_pkg::UCF_CTRL_ADDR && reg_addr != ucf_pkg::UCF_STAT_ADDR
      |=> reg_rdata == ucf_pkg::UCF_RD_IDLE)
      else $error("unmapped read returned data");

   a_cfg_write_lands: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && reg_addr >= ucf_pkg::UCF_PAT1_ADDR && reg_addr <= ucf_pkg::UCF_MSK4_ADDR
      |=> cfg_q[3'($past(reg_addr) - ucf_pkg::UCF_PAT1_ADDR)] == $past(reg_wdata))
      else $error("pattern or mask write did not land");

   a_cfg_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
      !reg_wr
      |=> $stable(cfg_q))
      else $error("pattern or mask changed without a write");

   a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_wr && reg_addr == ucf_pkg::UCF_CTRL_ADDR
      |=> ctrl_q == $past(reg_wdata))
      else $error("control write did not land");

   a_ctrl_holds: assert property (@(posedge sys_clk) disable iff (!rstn)
      !(reg_wr && reg_addr == ucf_pkg::UCF_CTRL_ADDR)
      |=> $stable(ctrl_q))
      else $error("control changed without a write");

   a_verdict_status: assert property (@(posedge sys_clk) disable iff (!rstn)
      match_valid
      |=> stat_q[ucf_pkg::UCF_STAT_MATCH_BIT] == $past(user_match))
      else $error("status verdict bit not updated");

   a_sticky_set: assert property (@(posedge sys_clk) disable iff (!rstn)
      user_match
      |=> stat_q[ucf_pkg::UCF_STAT_SEEN_BIT])
      else $error("sticky match bit not set");

   a_sticky_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_STAT_ADDR && !user_match
      |=> !stat_q[ucf_pkg::UCF_STAT_SEEN_BIT])
      else $error("sticky match bit not cleared by read");

   a_stat_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_STAT_ADDR
      |=> reg_rdata == $past(stat_q))
      else $error("status read returned wrong value");

   a_pat1_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_PAT1_ADDR
      |=> reg_rdata == $past(user_filter_pattern_byte1))
      else $error("byte 1 pattern read returned wrong value");

   a_pat3_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_PAT3_ADDR
      |=> reg_rdata == $past(user_filter_pattern_byte3))
      else $error("byte 3 pattern read returned wrong value");

   a_pat4_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_PAT4_ADDR
      |=> reg_rdata == $past(user_filter_pattern_byte4))
      else $error("byte 4 pattern read returned wrong value");

   a_msk1_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_MSK1_ADDR
      |=> reg_rdata == $past(user_filter_mask_byte1))
      else $error("byte 1 mask read returned wrong value");

   a_msk4_readback: assert property (@(posedge sys_clk) disable iff (!rstn)
      reg_rd && reg_addr == ucf_pkg::UCF_MSK4_ADDR
      |=> reg_rdata == $past(user_filter_mask_byte4))
      else $error("byte 4 mask read returned wrong value");

endmodule // ucf_filter

/* File: bench/ucf_filter_test.sv */
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module ucf_filter_test;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic hdr_valid = 1'b0;
   ucf_pkg::ucf_hdr_t hdr = '0;
   logic match_valid;
   logic user_match;
   int fail_count = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'd75328;
   logic [7:0] regs [logic [7:0]];
   logic [7:0] addrs [11] = '{8'h58, 8'h59, 8'h5a, 8'h5b, 8'h5c, 8'h5d, 8'h5e, 8'h5f, 8'h40, 8'h30, 8'h41};
   logic [7:0] rd_q [$];
   logic hd_q [$];
   logic rd_prev = 1'b0;
   logic [7:0] stat_exp = 8'h00;
   logic [1:0] pv_valid = 2'b00;
   logic [1:0] pv_match = 2'b00;
   logic stat_rd_prev = 1'b0;
   logic [7:0] exp_rd;
   logic exp_hd;

   ucf_filter i_ucf_filter (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hdr_valid(hdr_valid), .hdr(hdr),
      .match_valid(match_valid), .user_match(user_match));

   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [31:0] cfg(input logic [7:0] base);
      return {regs[base], regs[base + 8'h01], regs[base + 8'h02], regs[base + 8'h03]};
   endfunction

   // one call per cycle, so no strobe is assigned twice in one time step
   task automatic cyc(input logic w, input logic r, input logic v, input logic [7:0] a, input logic [7:0] d,
         input logic [31:0] h);
      logic hv;
      logic hm;
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= r;
      hdr_valid <= v;
      reg_addr <= a;
      reg_wdata <= d;
      hdr <= h;
      // status lags a header by two edges; a match two calls back beats a clearing read
      if (pv_valid[1]) stat_exp[0] = pv_match[1];
      if (pv_match[1]) stat_exp[1] = 1'b1;
      else if (stat_rd_prev) stat_exp[1] = 1'b0;
      // a header beside a write still sees the old configuration
      hv = v && regs[8'h40][0];
      hm = hv && (((h ^ cfg(8'h58)) & cfg(8'h5c)) == 32'h0);
      if (hv) hd_q.push_back(hm);
      if (w && regs.exists(a)) regs[a] = d;
      if (r) rd_q.push_back(a == 8'h41 ? stat_exp : (regs.exists(a) ? regs[a] : 8'h00));
      pv_valid = {pv_valid[0], hv};
      pv_match = {pv_match[0], hm};
      stat_rd_prev = r && a == 8'h41;
   endtask

   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(negedge sys_clk) begin
      if (rstn) begin
         if (rd_prev) begin
            exp_rd = rd_q.pop_front();
            `CHK(reg_rdata, exp_rd)
         end else begin
            `CHK(reg_rdata, 8'h00)
         end
         rd_prev = reg_rd;
         if (match_valid === 1'b1) begin
            if (hd_q.size() == 0) begin
               `CHK(match_valid, 1'b0)
            end else begin
               exp_hd = hd_q.pop_front();
               `CHK(user_match, exp_hd)
            end
         end else begin
            `CHK(user_match, 1'b0)
         end
      end
   end

   initial begin
      #(25ns * 4000);
      fail_count++;
      complete_run();
   end

   initial begin
      logic [31:0] r;
      logic [31:0] h;
      logic [7:0] a;
      logic [7:0] d;
      for (int i = 0; i < 4; i++) begin
         regs[8'(8'h58 + i)] = 8'h00;
         regs[8'(8'h5c + i)] = 8'hff;
      end
      regs[8'h40] = 8'h01;
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      foreach (addrs[i]) cyc(1'b0, 1'b1, 1'b0, addrs[i], 8'h00, 32'h0);
      // defaults: all bits compared against zero
      cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 32'h0);
      cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 32'h0000_0001);
      cyc(1'b1, 1'b0, 1'b0, 8'h5d, 8'h0f, 32'h0);
      cyc(1'b0, 1'b1, 1'b1, 8'h5d, 8'h00, 32'h00f0_0000);
      // back-to-back mask readback, then a pattern write seen by the very next header
      cyc(1'b1, 1'b0, 1'b0, 8'h5e, 8'h3c, 32'h0);
      cyc(1'b0, 1'b1, 1'b0, 8'h5e, 8'h00, 32'h0);
      cyc(1'b1, 1'b0, 1'b0, 8'h59, 8'ha5, 32'h0);
      cyc(1'b0, 1'b0, 1'b1, 8'h00, 8'h00, 32'h00a5_0000);
      cyc(1'b0, 1'b1, 1'b0, 8'h59, 8'h00, 32'h0);
      // status twice: the first read clears the sticky bit
      cyc(1'b0, 1'b1, 1'b0, 8'h41, 8'h00, 32'h0);
      cyc(1'b0, 1'b1, 1'b0, 8'h41, 8'h00, 32'h0);
      // mixed traffic; matches are steered often, some one bit off
      for (int i = 0; i < 1500; i++) begin
         r = rnd();
         h = rnd();
         a = addrs[r[3:0] % 11];
         d = r[31:24];
         if (a == 8'h40) d[0] = r[18] | r[19];
         if (r[4]) h = cfg(8'h58) ^ (h & ~cfg(8'h5c)) ^ (r[5] ? (32'h1 << r[12:8]) : 32'h0);
         cyc(r[7:6] == 2'd0, r[7:6] == 2'd1, r[16] | r[17], a, d, h);
      end
      repeat (3) cyc(1'b0, 1'b0, 1'b0, 8'h00, 8'h00, 32'h0);
      `CHK(hd_q.size() + rd_q.size(), 0)
      complete_run();
   end
endmodule // ucf_filter_test
